/* rtl/lacf_pkg.sv */
`default_nettype none
package lacf_pkg;
  localparam int unsigned APB_AW = 12;
  localparam int unsigned NUM_CH = 3;
  localparam logic [APB_AW-1:0] CTRL_OFFSET = 12'h028;
  localparam logic [APB_AW-1:0] STATUS_OFFSET = 12'h02C;
  localparam logic [APB_AW-1:0] CRD_STATUS_OFFSET = 12'h030;
  localparam int unsigned ACK_LIMIT_LSB = 0;
  localparam int unsigned ACK_LIMIT_W = 8;
  localparam int unsigned FLUSH_DELAY_LSB = 8;
  localparam int unsigned FLUSH_DELAY_W = 10;
  localparam logic [ACK_LIMIT_W-1:0] ACK_LIMIT_RESET = 8'h10;
  localparam logic [FLUSH_DELAY_W-1:0] FLUSH_DELAY_RESET = 10'h020;
  localparam int unsigned TIMER_W = 10;
  localparam logic [TIMER_W-1:0] TIMER_MAX = 10'h3FF;
  localparam int unsigned STAT_ACK_LSB = 0;
  localparam int unsigned STAT_FREE_LSB = 8;
  localparam int unsigned STAT_TIMER_LSB = 16;
  localparam int unsigned STAT_FORCE_BIT = 26;
  localparam logic [7:0] HDR_ACK_VALUE = 8'h08;
  localparam logic [7:0] ACK_IDLE_FLOOR = 8'h01;
  localparam logic [7:0] RETRY_BUF_SIZE = 8'hFF;
  localparam logic [7:0] MIN_FREE_TO_SEND = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam real LINK_CLK_MHZ = 40.0;

  typedef struct packed {
    logic [7:0] full_ack;
    logic [NUM_CH-1:0][7:0] crd;
  } lacf_crd_flit_t;

  typedef struct packed {
    logic hdr_ack_bit;
    logic [7:0] full_ack;
  } lacf_rx_ack_t;
endpackage : lacf_pkg
`default_nettype wire

/* rtl/lacf_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lacf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lacf_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_flit_stored,
  input wire logic rx_ack_valid,
  input wire lacf_pkg::lacf_rx_ack_t rx_ack,
  input wire logic rx_retryable_flit,
  input wire logic [lacf_pkg::NUM_CH-1:0] crd_inc,
  input wire logic hdr_flit_send,
  input wire logic other_ll_pending,
  input wire logic tx_slot_free,
  output logic tx_room,
  output logic hdr_ack_bit,
  output logic force_req,
  output logic credit_flit_fire,
  output logic credit_flit_valid,
  output lacf_pkg::lacf_crd_flit_t credit_flit
);
  import lacf_pkg::*;

  // Clamped add/subtract so counters never wrap on bursty traffic
  function automatic logic [7:0] upd8(input logic [7:0] cur, input logic [7:0] add,
                                      input logic [7:0] sub);
    logic [9:0] t;
    t = {2'b00, cur} + {2'b00, add};
    if (t < {2'b00, sub}) begin
      upd8 = 8'h00;
    end else if ((t - {2'b00, sub}) > {2'b00, CNT_MAX}) begin
      upd8 = CNT_MAX;
    end else begin
      upd8 = 8'(t - {2'b00, sub});
    end
  endfunction : upd8

  logic [ACK_LIMIT_W-1:0] ack_limit;
  logic [FLUSH_DELAY_W-1:0] flush_delay;
  logic [7:0] pend_ack;
  logic [NUM_CH-1:0][7:0] pend_crd;
  logic [7:0] free_retry_entries;
  logic [TIMER_W-1:0] idle_timer;
  logic [TIMER_W-1:0] next_idle_timer;
  logic [7:0] next_pend_ack;
  logic [NUM_CH-1:0][7:0] next_pend_crd;
  logic [7:0] next_free;
  logic [7:0] rx_ack_amount;
  logic [7:0] ack_dec;
  logic hdr_ack_sent;
  logic sending_ackcrd;
  logic any_crd;
  logic apb_setup;
  logic apb_write;
  logic addr_hit;
  logic [31:0] rd_value;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_merged;

  // Link-layer clock is pclk here; one flit slot per cycle
  // Room means more than one free entry: a full and empty buffer look alike
  assign tx_room = free_retry_entries > MIN_FREE_TO_SEND;

  assign hdr_ack_bit = pend_ack >= HDR_ACK_VALUE;
  assign hdr_ack_sent = hdr_flit_send && hdr_ack_bit;

  assign force_req = (idle_timer >= flush_delay) || (pend_ack >= ack_limit);

  // Lowest priority slot user; waiting is safe because the timer holds
  assign credit_flit_fire = force_req && tx_slot_free && !other_ll_pending
                            && !hdr_flit_send && tx_room;

  assign sending_ackcrd = credit_flit_fire || hdr_ack_sent;
  assign any_crd = |pend_crd;

  always_comb begin
    rx_ack_amount = 8'h00;
    if (rx_ack_valid) begin
      rx_ack_amount = rx_ack.hdr_ack_bit ? HDR_ACK_VALUE : rx_ack.full_ack;
    end
  end

  always_comb begin
    next_free = upd8(free_retry_entries, rx_ack_amount, {7'h00, tx_flit_stored});
  end

  always_comb begin
    ack_dec = 8'h00;
    if (credit_flit_fire) begin
      ack_dec = pend_ack;
    end else if (hdr_ack_sent) begin
      ack_dec = HDR_ACK_VALUE;
    end
    next_pend_ack = upd8(pend_ack, {7'h00, rx_retryable_flit}, ack_dec);
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      // Credits arriving in the firing cycle stay pending, not lost
      next_pend_crd[i] = upd8(pend_crd[i], {7'h00, crd_inc[i]},
                              credit_flit_fire ? pend_crd[i] : 8'h00);
    end
  end

  always_comb begin
    next_idle_timer = '0;
    if (sending_ackcrd) begin
      next_idle_timer = '0;
    end else if ((pend_ack > ACK_IDLE_FLOOR) || any_crd) begin
      // Floor of one keeps an idle link from ping-ponging acks forever
      if (idle_timer != TIMER_MAX) begin
        next_idle_timer = idle_timer + 10'h001;
      end else begin
        next_idle_timer = idle_timer;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_timer <= '0;
    end else begin
      idle_timer <= next_idle_timer;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ack <= 8'h00;
      pend_crd <= '0;
    end else begin
      pend_ack <= next_pend_ack;
      pend_crd <= next_pend_crd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_retry_entries <= RETRY_BUF_SIZE;
    end else begin
      free_retry_entries <= next_free;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      credit_flit_valid <= 1'b0;
      credit_flit <= '0;
    end else begin
      credit_flit_valid <= credit_flit_fire;
      if (credit_flit_fire) begin
        credit_flit.full_ack <= pend_ack;
        credit_flit.crd <= pend_crd;
      end
    end
  end

  // APB slave, zero wait states; read data captured in the setup cycle
  assign pready = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign addr_hit = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET)
                    || (paddr == CRD_STATUS_OFFSET);

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[ACK_LIMIT_LSB +: ACK_LIMIT_W] = ack_limit;
    ctrl_word[FLUSH_DELAY_LSB +: FLUSH_DELAY_W] = flush_delay;
    for (int b = 0; b < 4; b++) begin
      ctrl_merged[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : ctrl_word[b*8 +: 8];
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    case (paddr)
      CTRL_OFFSET: begin
        rd_value = ctrl_word;
      end
      STATUS_OFFSET: begin
        rd_value[STAT_ACK_LSB +: 8] = pend_ack;
        rd_value[STAT_FREE_LSB +: 8] = free_retry_entries;
        rd_value[STAT_TIMER_LSB +: TIMER_W] = idle_timer;
        rd_value[STAT_FORCE_BIT] = force_req;
      end
      CRD_STATUS_OFFSET: begin
        rd_value[NUM_CH*8-1:0] = pend_crd;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr <= !addr_hit;
    end
  end

  // Sticky fields: only presetn clears them; no soft reset exists here
  // Values below the recommended minimum are stored as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_limit <= ACK_LIMIT_RESET;
      flush_delay <= FLUSH_DELAY_RESET;
    end else if (apb_write && (paddr == CTRL_OFFSET)) begin
      ack_limit <= ctrl_merged[ACK_LIMIT_LSB +: ACK_LIMIT_W];
      flush_delay <= ctrl_merged[FLUSH_DELAY_LSB +: FLUSH_DELAY_W];
    end
  end
endmodule : lacf_top
`default_nettype wire

/* test/lacf_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module lacf_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_flit_stored,
  input wire logic rx_retryable_flit,
  input wire logic [lacf_pkg::NUM_CH-1:0] crd_inc,
  input wire logic hdr_flit_send,
  input wire logic other_ll_pending,
  input wire logic tx_room,
  input wire logic hdr_ack_bit,
  input wire logic force_req,
  input wire logic credit_flit_fire,
  input wire logic credit_flit_valid
);
  import lacf_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acks; (rx_retryable_flit && !credit_flit_fire && !hdr_flit_send)[*8]; endsequence
  property p_lim; s_acks ##1 s_acks |=> force_req; endproperty
  a_lim: assert property (p_lim) else $error("no force at limit");
  property p_fire; credit_flit_fire |-> force_req && !other_ll_pending; endproperty
  a_fire: assert property (p_fire) else $error("bad fire");
  property p_val; credit_flit_fire |=> credit_flit_valid; endproperty
  a_val: assert property (p_val) else $error("no valid");
  property p_nval; !credit_flit_fire |=> !credit_flit_valid; endproperty
  a_nval: assert property (p_nval) else $error("stray valid");
  property p_clr; credit_flit_fire && !rx_retryable_flit && !(|crd_inc) |=> !force_req;
  endproperty
  a_clr: assert property (p_clr) else $error("force kept");
  property p_hdr; $rose(hdr_ack_bit) |-> $past(rx_retryable_flit); endproperty
  a_hdr: assert property (p_hdr) else $error("early ack bit");
  property p_room; $fell(tx_room) |-> $past(tx_flit_stored); endproperty
  a_room: assert property (p_room) else $error("room lost");
  property p_hold; force_req && !credit_flit_fire && !hdr_flit_send |=> force_req; endproperty
  a_hold: assert property (p_hold) else $error("force dropped");
endmodule : lacf_monitor
bind lacf_top lacf_monitor u_mon (.*);
`default_nettype wire

/* test/lacf_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module lacf_peer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_flit_stored,
  input wire logic ack_en,
  input wire logic flit_en,
  output lacf_pkg::lacf_rx_ack_t rx_ack,
  output logic rx_ack_valid,
  output logic rx_retryable_flit
);
  import lacf_pkg::*;
  logic [7:0] owed;
  logic [7:0] ret;
  logic go;
  assign go = ack_en && owed != 8'h00;
  assign ret = (owed >= HDR_ACK_VALUE) ? HDR_ACK_VALUE : owed;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {owed, rx_ack, rx_ack_valid, rx_retryable_flit} <= '0;
    end else begin
      owed <= owed + {7'h00, tx_flit_stored} - (go ? ret : 8'h00);
      // Idle ack field toggles so a stale value is never mistaken for data
      rx_ack <= go ? {owed >= HDR_ACK_VALUE, ret} : ~rx_ack;
      rx_ack_valid <= go;
      rx_retryable_flit <= flit_en;
    end
  end
endmodule : lacf_peer
`default_nettype wire

/* test/lacf_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module lacf_top_test;
  import lacf_pkg::*;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, fls = '0, ake = '0;
  logic fle = '0, oth = '0, slot = '0, e, pready, pslverr, room, hak, frc, fire, cval, rxv, rxf;
  logic hfs = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [2:0] crd = '0;
  lacf_rx_ack_t rxa;
  lacf_crd_flit_t cfl;
  int fails = 0, compares = 0, n;
  always #12.5 pclk = ~pclk;
  lacf_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .tx_flit_stored(fls), .rx_ack_valid(rxv), .rx_ack(rxa),
    .rx_retryable_flit(rxf), .crd_inc(crd), .hdr_flit_send(hfs), .other_ll_pending(oth),
    .tx_slot_free(slot), .tx_room(room), .hdr_ack_bit(hak), .force_req(frc),
    .credit_flit_fire(fire), .credit_flit_valid(cval), .credit_flit(cfl));
  lacf_peer peer (.pclk, .presetn, .tx_flit_stored(fls), .ack_en(ake), .flit_en(fle),
    .rx_ack(rxa), .rx_ack_valid(rxv), .rx_retryable_flit(rxf));
  task chk(input string s, input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task tick(input int k); repeat (k) @(posedge pclk); #1; endtask : tick
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'h1);
    rd = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task t_regs;
    apb(1'h0, CTRL_OFFSET, 32'h0);
    chk("ctrl reset", rd, 32'h0000_2010);
    apb(1'h1, CTRL_OFFSET, 32'hFFFF_FFFF);
    apb(1'h0, CTRL_OFFSET, 32'h0);
    chk("ctrl fields", rd, 32'h0003_FFFF);
    apb(1'h1, CTRL_OFFSET, 32'h0000_2010);
    apb(1'h0, 12'h100, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    $display("registers done");
  endtask : t_regs
  task t_limit;
    @(posedge pclk);
    {oth, slot, fle} <= 3'h7;
    repeat (16) @(posedge pclk);
    fle <= 1'h0;
    tick(2);
    chk("force", {31'h0, frc}, 32'h1);
    chk("blocked", {31'h0, fire}, 32'h0);
    chk("ack bit", {31'h0, hak}, 32'h1);
    oth <= 1'h0;
    tick(1);
    chk("flit acks", cfl, 32'h1000_0000);
    chk("cleared", {31'h0, frc}, 32'h0);
    $display("limit done");
  endtask : t_limit
  task t_hdr;
    fle <= 1'h1;
    tick(10);
    fle <= 1'h0;
    tick(2);
    chk("hdr bit", {31'h0, hak}, 32'h1);
    hfs <= 1'h1;
    tick(1);
    hfs <= 1'h0;
    apb(1'h0, STATUS_OFFSET, 32'h0);
    chk("hdr deduct", {24'h0, rd[7:0]}, 32'h2);
    tick(40);
    chk("idle flush", cfl, 32'h0200_0000);
    $display("header done");
  endtask : t_hdr
  task t_timer;
    {slot, fle} <= 2'h1;
    tick(1);
    fle <= 1'h0;
    tick(40);
    chk("one ack idle", {31'h0, frc}, 32'h0);
    crd <= 3'h2;
    tick(1);
    crd <= 3'h0;
    n = 0;
    do begin tick(1); n++; end while (frc !== 1'h1 && n < 100);
    chk("delay", n, 32'h20);
    slot <= 1'h1;
    tick(1);
    chk("flit credits", cfl, 32'h0100_0100);
    $display("timer done");
  endtask : t_timer
  task t_room;
    fls <= 1'h1;
    tick(253);
    chk("room two", {31'h0, room}, 32'h1);
    tick(1);
    fls <= 1'h0;
    chk("room one", {31'h0, room}, 32'h0);
    ake <= 1'h1;
    tick(1);
    ake <= 1'h0;
    tick(3);
    apb(1'h0, STATUS_OFFSET, 32'h0);
    chk("free", {24'h0, rd[15:8]}, 32'h9);
    $display("room done");
  endtask : t_room
  task results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_limit;
    t_hdr;
    t_timer;
    t_room;
    results;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    results;
  end
endmodule : lacf_top_test
`default_nettype wire
